// *** logic/lcd_display_ram.sv ***
// Display data memory: four pages of eighty byte columns.
// Assumes the caller never writes at a column at or above the limit.
`timescale 1ns/1ps
`include "lcd_ctrl_map.svh"

module lcd_display_ram (
  input  wire logic       sys_clk_in,   // System clock
  input  wire logic       wr_en_in,     // Write this cycle
  input  wire logic [1:0] page_in,      // Page address
  input  wire logic [6:0] col_in,       // Column address
  input  wire logic [7:0] wdata_in,     // Byte to store
  output logic      [7:0] rdata_out     // Byte at page and column
);

  // No reset: contents survive every reset on purpose
  logic [7:0] mem [0:`DRAM_WORDS-1];
  logic [8:0] idx;                      // Flat word index

  // Page times eighty plus column, built from shifts
  always_comb begin
    idx = {1'b0, page_in, 6'h00} + {3'h0, page_in, 4'h0} + {2'h0, col_in};
  end

  // Invalid columns read as zero instead of wrapping
  always_comb begin
    if (col_in < `COL_LIMIT) begin
      rdata_out = mem[idx];
    end else begin
      rdata_out = 8'h00;
    end
  end

  // Write port
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      mem[idx] <= wdata_in;
    end
  end

endmodule : lcd_display_ram

// *** logic/lcd_rmw_reset_powersave_ctrl.sv ***
// Command slice of a dot-matrix LCD controller: read-modify-write, End,
// software reset, power save, data access and hardware init settling.
// Assumes host strobes are synchronous one-cycle pulses on sys_clk_in.
`timescale 1ns/1ps
`include "lcd_ctrl_map.svh"

module lcd_rmw_reset_powersave_ctrl (
  input  wire logic                    sys_clk_in,     // 100 MHz clock
  input  wire logic                    rst_n_in,       // Async reset
  input  wire logic                    hw_init_pin_in, // Edge resets
  input  wire lcd_ctrl_pkg::bus_req_t  bus_req_in,     // Host access
  output logic      [7:0]              bus_rdata_out,  // Read byte
  output lcd_ctrl_pkg::drive_ctl_t     drive_out,      // Drive controls
  output logic                         power_save_out, // Power save
  output logic                         display_on_out, // Display on
  output logic                         static_drive_out, // Static
  output logic                         adc_select_out, // Column order
  output logic                         duty_select_out, // Duty select
  output logic      [4:0]              start_line_out, // Start line
  output logic      [1:0]              page_out,       // Page register
  output logic      [6:0]              column_out,     // Column counter
  output logic                         rmw_active_out, // In RMW mode
  output logic                         resetting_out   // Init settling
);

  localparam logic [6:0] SETTLE_CNT = 7'(`INIT_SETTLE_CYC);

  lcd_ctrl_pkg::mode_t mode_q, mode_d;  // Operating mode
  logic [6:0] cnt_q, cnt_d;             // Settle countdown
  logic [6:0] col_q, col_d;             // Column address counter
  logic [6:0] save_q, save_d;           // Column saved at RMW entry
  logic [1:0] page_q, page_d;           // Page register
  logic [4:0] start_q, start_d;         // Display start line
  logic       disp_on_q, disp_on_d;     // Display-on flag
  logic       static_q, static_d;       // Static drive flag
  logic       adc_q, adc_d;             // Column order flag
  logic       duty_q, duty_d;           // Duty flag
  logic [7:0] latch_q, latch_d;         // Data I/O latch
  logic [7:0] rdata_q, rdata_d;         // Byte presented to host
  logic       pin_q;                    // Last init pin level
  logic       pin_edge;                 // Either edge on init pin
  logic       ram_we;                   // Memory write enable
  logic [7:0] ram_rdata;                // Memory byte at address
  logic       accept;                   // Commands taken
  logic       col_inc;                  // Advance column this cycle
  logic       psave;                    // Power save state

  // Exact command match, decoded in many places
  function automatic logic is_cmd(input lcd_ctrl_pkg::bus_req_t r,
                                  input logic [7:0] code);
    return r.wr && !r.cds && (r.data == code);
  endfunction : is_cmd

  lcd_display_ram u_dram (
    .sys_clk_in (sys_clk_in),
    .wr_en_in   (ram_we),
    .page_in    (page_q),
    .col_in     (col_q),
    .wdata_in   (bus_req_in.data),
    .rdata_out  (ram_rdata)
  );

  // Pin is synchronous, so one flop is enough for edge sensing
  assign pin_edge = hw_init_pin_in ^ pin_q;
  assign accept   = (mode_q != lcd_ctrl_pkg::MODE_INIT);

  // Next-state logic for mode, counters and settings
  always_comb begin
    mode_d    = mode_q;
    cnt_d     = cnt_q;
    col_d     = col_q;
    save_d    = save_q;
    page_d    = page_q;
    start_d   = start_q;
    disp_on_d = disp_on_q;
    static_d  = static_q;
    adc_d     = adc_q;
    duty_d    = duty_q;
    latch_d   = latch_q;
    rdata_d   = rdata_q;
    ram_we    = 1'b0;
    col_inc   = 1'b0;
    unique case (mode_q)
      lcd_ctrl_pkg::MODE_INIT: begin
        if (cnt_q == 7'h00) mode_d = lcd_ctrl_pkg::MODE_NORMAL;
        else cnt_d = cnt_q - 7'h01;
      end
      lcd_ctrl_pkg::MODE_NORMAL: begin
        if (is_cmd(bus_req_in, `CMD_RMW_ENTER)) begin
          mode_d = lcd_ctrl_pkg::MODE_RMW;
          save_d = col_q;
        end
      end
      lcd_ctrl_pkg::MODE_RMW: begin
        if (is_cmd(bus_req_in, `CMD_RMW_END)) begin
          mode_d = lcd_ctrl_pkg::MODE_NORMAL;
          col_d  = save_q;
        end
      end
    endcase
    if (accept) begin
      // Soft reset; memory write stays off
      if (is_cmd(bus_req_in, `CMD_SOFT_RESET)) begin
        start_d = `START_RESET;
        page_d  = `PAGE_RESET;
      end
      if (is_cmd(bus_req_in, `CMD_DISP_OFF)) disp_on_d = 1'b0;
      if (is_cmd(bus_req_in, `CMD_DISP_ON))  disp_on_d = 1'b1;
      if (is_cmd(bus_req_in, `CMD_STATIC_OFF)) static_d = 1'b0;
      if (is_cmd(bus_req_in, `CMD_STATIC_ON))  static_d = 1'b1;
      if (is_cmd(bus_req_in, `CMD_ADC_NORMAL)) adc_d = 1'b0;
      if (is_cmd(bus_req_in, `CMD_ADC_INVERT)) adc_d = 1'b1;
      if (is_cmd(bus_req_in, `CMD_DUTY_LOW))   duty_d = 1'b0;
      if (is_cmd(bus_req_in, `CMD_DUTY_HIGH))  duty_d = 1'b1;
      // Operand commands
      if (bus_req_in.wr && !bus_req_in.cds) begin
        if (bus_req_in.data[7:5] == `CMD_START_PREFIX) begin
          start_d = bus_req_in.data[4:0];
        end
        if (bus_req_in.data[7:2] == `CMD_PAGE_PREFIX) begin
          page_d = bus_req_in.data[1:0];
        end
        // Honoured even in RMW; host keeps it out of that mode
        if (!bus_req_in.data[7]) col_d = bus_req_in.data[6:0];
      end
      // Data write stores and advances in both NORMAL and RMW modes
      if (bus_req_in.wr && bus_req_in.cds) begin
        ram_we  = (col_q < `COL_LIMIT);
        col_inc = 1'b1;
      end
      // Data read hands out the latch and refills it
      if (bus_req_in.rd && bus_req_in.cds) begin
        rdata_d = latch_q;
        latch_d = ram_rdata;
        // No advance on reads in RMW
        col_inc = (mode_q != lcd_ctrl_pkg::MODE_RMW);
      end
      // Status read: busy, column order, display off, resetting
      if (bus_req_in.rd && !bus_req_in.cds) begin
        rdata_d = {1'b0, adc_q, !disp_on_q, 1'b0, 4'h0};
      end
    end
    // Counter saturates at the limit
    if (col_inc && (col_q < `COL_LIMIT)) col_d = col_q + 7'h01;
    // Any init edge restarts the settle period
    if (pin_edge) begin
      mode_d    = lcd_ctrl_pkg::MODE_INIT;
      cnt_d     = SETTLE_CNT;
      col_d     = `COL_RESET;
      page_d    = `PAGE_RESET;
      start_d   = `START_RESET;
      disp_on_d = 1'b0;
      static_d  = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q    <= lcd_ctrl_pkg::MODE_INIT;
      cnt_q     <= SETTLE_CNT;
      col_q     <= `COL_RESET;
      save_q    <= `COL_RESET;
      page_q    <= `PAGE_RESET;
      start_q   <= `START_RESET;
      disp_on_q <= 1'b0;
      static_q  <= 1'b0;
      adc_q     <= 1'b0;
      duty_q    <= 1'b0;
      latch_q   <= 8'h00;
      rdata_q   <= 8'h00;
      pin_q     <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      cnt_q     <= cnt_d;
      col_q     <= col_d;
      save_q    <= save_d;
      page_q    <= page_d;
      start_q   <= start_d;
      disp_on_q <= disp_on_d;
      static_q  <= static_d;
      adc_q     <= adc_d;
      duty_q    <= duty_d;
      latch_q   <= latch_d;
      rdata_q   <= rdata_d;
      pin_q     <= hw_init_pin_in;
    end
  end

  // Power save follows the two flags directly
  assign psave = static_q && !disp_on_q;

  always_comb begin
    drive_out.lcd_drive_on       = !psave;
    drive_out.column_drivers_vdd = psave;
    drive_out.row_drivers_vdd    = psave;
    drive_out.row_select_all     = static_q && !psave;
    drive_out.osc_clk_block      = psave;
    drive_out.osc_out_oe         = !psave;
  end

  assign power_save_out   = psave;
  assign bus_rdata_out    = rdata_q;
  assign display_on_out   = disp_on_q;
  assign static_drive_out = static_q;
  assign adc_select_out   = adc_q;
  assign duty_select_out  = duty_q;
  assign start_line_out   = start_q;
  assign page_out         = page_q;
  assign column_out       = col_q;
  assign rmw_active_out   = (mode_q == lcd_ctrl_pkg::MODE_RMW);
  assign resetting_out    = !accept;

  // Checks
  sequence s_rmw_enter;
    mode_q == lcd_ctrl_pkg::MODE_NORMAL && !pin_edge &&
    is_cmd(bus_req_in, `CMD_RMW_ENTER);
  endsequence
  sequence s_rmw_end;
    mode_q == lcd_ctrl_pkg::MODE_RMW && !pin_edge &&
    is_cmd(bus_req_in, `CMD_RMW_END);
  endsequence

  rmw_enter_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_rmw_enter |=> rmw_active_out && save_q == $past(col_q))
    else $error("RMW entry did not save column");
  rmw_end_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_rmw_end |=> !rmw_active_out && col_q == $past(save_q))
    else $error("End did not restore column");
  rmw_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rmw_active_out && !pin_edge && !is_cmd(bus_req_in, `CMD_RMW_END)
      |=> rmw_active_out && $stable(save_q))
    else $error("RMW mode or saved column lost without End");
  rmw_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rmw_active_out && !pin_edge && bus_req_in.rd && bus_req_in.cds
      |=> $stable(col_q))
    else $error("Read advanced column in RMW");
  write_inc_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    accept && !pin_edge && bus_req_in.wr && bus_req_in.cds &&
    col_q < `COL_LIMIT |-> ram_we ##1 col_q == $past(col_q) + 7'h01)
    else $error("Data write did not store and advance");
  read_latch_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    accept && bus_req_in.rd && bus_req_in.cds
      |=> bus_rdata_out == $past(latch_q) && latch_q == $past(ram_rdata))
    else $error("Data read did not pass the latch");
  soft_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    accept && is_cmd(bus_req_in, `CMD_SOFT_RESET)
      |-> !ram_we ##1 start_line_out == 5'h00 && page_out == 2'h3)
    else $error("Soft reset values wrong");
  power_save_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    accept && !pin_edge && !disp_on_q && is_cmd(bus_req_in, `CMD_STATIC_ON)
      |=> power_save_out && drive_out.column_drivers_vdd &&
          drive_out.row_drivers_vdd && drive_out.osc_clk_block &&
          !drive_out.osc_out_oe && !drive_out.lcd_drive_on)
    else $error("Power save not entered or drivers not parked");
  psave_exit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    power_save_out && accept && !pin_edge &&
    (is_cmd(bus_req_in, `CMD_DISP_ON) || is_cmd(bus_req_in, `CMD_STATIC_OFF))
      |=> !power_save_out && drive_out.lcd_drive_on)
    else $error("Power save not left");
  psave_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    power_save_out && !bus_req_in.wr && !pin_edge
      |=> $stable(start_q) && $stable(page_q) && $stable(adc_q) &&
          $stable(duty_q))
    else $error("Settings changed in power save");
  settle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    pin_edge ##1 (!pin_edge)[*8] |-> resetting_out)
    else $error("Left init before settle time");
  settle_done_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $fell(resetting_out) |-> $past(resetting_out, `INIT_SETTLE_CYC + 1))
    else $error("Init settle ended early");

endmodule : lcd_rmw_reset_powersave_ctrl

// *** shared/lcd_ctrl_map.svh ***
// Constants for the LCD command slice: command codes, limits, reset values
// and the settle time after a hardware init edge.
// Assumes a 100 MHz system clock.
`ifndef LCD_CTRL_MAP_SVH
`define LCD_CTRL_MAP_SVH

// Exact command codes
`define CMD_RMW_ENTER    8'hE0
`define CMD_RMW_END      8'hEE
`define CMD_SOFT_RESET   8'hE2
`define CMD_DISP_OFF     8'hAE
`define CMD_DISP_ON      8'hAF
`define CMD_STATIC_OFF   8'hA4
`define CMD_STATIC_ON    8'hA5
`define CMD_ADC_NORMAL   8'hA0
`define CMD_ADC_INVERT   8'hA1
`define CMD_DUTY_LOW     8'hA8
`define CMD_DUTY_HIGH    8'hA9

// Prefix codes of the commands that carry an operand
`define CMD_START_PREFIX 3'h6
`define CMD_PAGE_PREFIX  6'h2E

// Column counter stops here; addresses at or above it are invalid
`define COL_LIMIT        7'h50
`define COL_RESET        7'h00
`define PAGE_RESET       2'h3
`define START_RESET      5'h00
`define DRAM_WORDS       320

// Settle time after an init edge, rounded up to whole cycles
`define CLK_PERIOD_NS    10
`define INIT_SETTLE_NS   1000
`define INIT_SETTLE_CYC  ((`INIT_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** shared/lcd_ctrl_pkg.sv ***
// Types shared by the LCD command slice, its host model and its bench.
// Holds no constants; those live in the map header.
package lcd_ctrl_pkg;

  // One host access, taken in the cycle its strobe is high
  typedef struct packed {
    logic       wr;    // Write strobe, one cycle
    logic       rd;    // Read strobe, one cycle
    logic       cds;   // cmd_data_select: 0 command, 1 display data
    logic [7:0] data;  // Write byte
  } bus_req_t;

  // LCD drive and oscillator controls
  typedef struct packed {
    logic lcd_drive_on;      // Drivers actively scanning
    logic column_drivers_vdd; // Column outputs parked at VDD
    logic row_drivers_vdd;   // Row outputs parked at VDD
    logic row_select_all;    // Static drive selects every row
    logic osc_clk_block;     // External clock input gated off
    logic osc_out_oe;        // Oscillator output driven
  } drive_ctl_t;

  // Operating modes, one-hot
  typedef enum logic [2:0] {
    MODE_INIT   = 3'b001,
    MODE_NORMAL = 3'b010,
    MODE_RMW    = 3'b100
  } mode_t;

endpackage : lcd_ctrl_pkg

// *** test/lcd_host_model.sv ***
// Host processor model: byte writes and reads, plus the init pin.
// Assumes the bench calls one task at a time, never overlapping.
`timescale 1ns/1ps
`include "lcd_ctrl_map.svh"

module lcd_host_model (
  input  wire logic              sys_clk_in,     // System clock
  input  wire logic [7:0]        rdata_in,       // Read byte from device
  output lcd_ctrl_pkg::bus_req_t bus_req_out,    // Host access
  output logic                   hw_init_pin_out // Init pin level
);
  logic in_rmw; // Host's own view of the mode

  initial begin
    bus_req_out     = '0;
    hw_init_pin_out = 1'b0;
    in_rmw          = 1'b0;
  end

  // One access: raised after a falling edge, held one full cycle
  task automatic access(input logic w, input logic c, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge sys_clk_in);
    bus_req_out = '{wr: w, rd: ~w, cds: c, data: d};
    @(negedge sys_clk_in);
    q = rdata_in;
    // Released bus shows the inverse, never the stale byte
    bus_req_out = '{wr: 1'b0, rd: 1'b0, cds: ~c, data: ~d};
  endtask : access

  task automatic wr_cmd(input logic [7:0] code);
    logic [7:0] q;
    if (in_rmw && !code[7]) return;
    if (code == `CMD_RMW_ENTER) in_rmw = 1'b1;
    if (code == `CMD_RMW_END) in_rmw = 1'b0;
    access(1'b1, 1'b0, code, q);
  endtask : wr_cmd

  task automatic wr_data(input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, 1'b1, d, q);
  endtask : wr_data

  task automatic rd(input logic c, output logic [7:0] q);
    access(1'b0, c, 8'h00, q);
  endtask : rd

  task automatic pulse_init;
    @(negedge sys_clk_in);
    hw_init_pin_out = ~hw_init_pin_out;
    in_rmw          = 1'b0;
  endtask : pulse_init
endmodule : lcd_host_model

// *** test/lcd_rmw_reset_powersave_ctrl_tb_top.sv ***
// Self-checking bench for the LCD command slice, random data, seed 59.
// Assumes the host model drives every access at the falling edge.
`timescale 1ns/1ps
`include "lcd_ctrl_map.svh"
`define CHK(nm, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("ERROR %s exp %h got %h", nm, exp, got); \
  end \
end

module lcd_rmw_reset_powersave_ctrl_tb_top;
  logic                     sys_clk_in, rst_n_in, hw_init_pin;
  lcd_ctrl_pkg::bus_req_t   bus_req;    // Host access
  lcd_ctrl_pkg::drive_ctl_t drive;      // Drive controls seen
  logic [7:0]               rdata;      // Read byte
  logic                     ps, disp, stat, adc, duty, rmw, resetting;
  logic [4:0]               start_line;
  logic [1:0]               page;
  logic [6:0]               column;
  logic [7:0]               mem [4][`DRAM_WORDS / 4]; // Expected RAM
  integer                   seed, miscompares, checks_done;

  lcd_rmw_reset_powersave_ctrl u_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .hw_init_pin_in(hw_init_pin), .bus_req_in(bus_req),
    .bus_rdata_out(rdata), .drive_out(drive), .power_save_out(ps),
    .display_on_out(disp), .static_drive_out(stat),
    .adc_select_out(adc), .duty_select_out(duty),
    .start_line_out(start_line), .page_out(page), .column_out(column),
    .rmw_active_out(rmw), .resetting_out(resetting));

  lcd_host_model u_host (
    .sys_clk_in(sys_clk_in), .rdata_in(rdata),
    .bus_req_out(bus_req), .hw_init_pin_out(hw_init_pin));

  // Free-running 100 MHz clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // Column saturates at the limit
  function automatic logic [6:0] next_col(input logic [6:0] c);
    return (c < `COL_LIMIT) ? c + 7'h01 : c;
  endfunction : next_col

  // Drive controls from display-on and static flags
  function automatic logic [5:0] exp_drive(input logic d, input logic s);
    logic p;
    p = s & ~d;
    return {~p, p, p, s & ~p, p, ~p};
  endfunction : exp_drive

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // Bounded wait for settling; counts cycles from the triggering edge
  task automatic wait_ready;
    int n;
    n = 0;
    repeat (3) if (resetting !== 1'b1) begin
      @(negedge sys_clk_in);
      n++;
    end
    while (resetting !== 1'b0 && n < 300) begin
      @(negedge sys_clk_in);
      n++;
    end
    `CHK("settle", 1'b1, n >= 100 && n <= 104)
    if (n >= 300) finish_test();
  endtask : wait_ready

  // Dummy read after a column load, then one real read
  task automatic read_at(input logic [6:0] c, output logic [7:0] q);
    u_host.wr_cmd({1'b0, c});
    u_host.rd(1'b1, q);
    u_host.rd(1'b1, q);
  endtask : read_at

  // Whole memory written; the extra write hits the limit
  task automatic fill_test;
    logic [7:0] d, q;
    for (int p = 0; p < 4; p++) begin
      u_host.wr_cmd({`CMD_PAGE_PREFIX, 2'(p)});
      u_host.wr_cmd(8'h00);
      for (int c = 0; c < `DRAM_WORDS / 4; c++) begin
        d = 8'($random(seed));
        u_host.wr_data(d);
        mem[p][c] = d;
        `CHK("column", next_col(7'(c)), column)
      end
      u_host.wr_data(8'h00);
      `CHK("column", `COL_LIMIT, column)
      read_at(7'h4F, q);
      `CHK("rdata", mem[p][79], q)
    end
    $display("fill test done");
  endtask : fill_test

  task automatic rmw_test;
    logic [1:0] p;
    logic [6:0] c;
    logic [7:0] q;
    p = 2'($random(seed));
    c = 7'($unsigned($random(seed)) % 72);
    u_host.wr_cmd({`CMD_PAGE_PREFIX, p});
    u_host.wr_cmd({1'b0, c});
    u_host.wr_cmd(`CMD_RMW_ENTER);
    `CHK("rmw", 1'b1, rmw)
    u_host.rd(1'b1, q);
    `CHK("column", c, column)
    u_host.wr_cmd(`CMD_DISP_ON);
    u_host.wr_cmd({1'b0, 7'h00});
    `CHK("rmw", 1'b1, rmw)
    u_host.rd(1'b1, q);
    `CHK("rdata", mem[p][c], q)
    mem[p][c] = ~q;
    u_host.wr_data(~q);
    `CHK("column", c + 7'h01, column)
    u_host.wr_cmd(`CMD_RMW_END);
    `CHK("rmw", 1'b0, rmw)
    `CHK("column", c, column)
    read_at(c, q);
    `CHK("rdata", mem[p][c], q)
    $display("rmw test done");
  endtask : rmw_test

  task automatic soft_reset_test;
    logic [4:0] s;
    logic [6:0] c;
    logic [7:0] q;
    s = 5'($random(seed));
    c = 7'($unsigned($random(seed)) % 80);
    u_host.wr_cmd({`CMD_START_PREFIX, s});
    u_host.wr_cmd({`CMD_PAGE_PREFIX, 2'($random(seed))});
    `CHK("start", s, start_line)
    u_host.wr_cmd(`CMD_SOFT_RESET);
    `CHK("start", `START_RESET, start_line)
    `CHK("page", `PAGE_RESET, page)
    read_at(c, q);
    `CHK("rdata", mem[3][c], q)
    $display("soft reset test done");
  endtask : soft_reset_test

  // Power save entered, settings kept, left by either exit
  task automatic ps_test(input logic by_disp);
    logic       a, u;
    logic [4:0] s;
    logic [7:0] q;
    a = 1'($random(seed));
    u = 1'($random(seed));
    s = 5'($random(seed));
    u_host.wr_cmd(`CMD_ADC_NORMAL | {7'h00, a});
    u_host.wr_cmd(`CMD_DUTY_LOW | {7'h00, u});
    u_host.wr_cmd({`CMD_START_PREFIX, s});
    u_host.wr_cmd(`CMD_DISP_OFF);
    `CHK("disp", 1'b0, disp)
    u_host.wr_cmd(`CMD_STATIC_ON);
    `CHK("static", 1'b1, stat)
    `CHK("ps", 1'b1, ps)
    `CHK("drive", exp_drive(1'b0, 1'b1), drive)
    u_host.rd(1'b0, q);
    `CHK("status", {1'b0, a, 6'h20}, q)
    `CHK("keep", {a, u, s}, {adc, duty, start_line})
    u_host.wr_cmd(by_disp ? `CMD_DISP_ON : `CMD_STATIC_OFF);
    `CHK("ps", 1'b0, ps)
    `CHK("drive", exp_drive(by_disp, by_disp), drive)
    u_host.wr_cmd(`CMD_STATIC_OFF);
    u_host.wr_cmd(`CMD_DISP_ON);
    `CHK("drive", exp_drive(1'b1, 1'b0), drive)
    $display("power save test done");
  endtask : ps_test

  initial begin
    seed        = 59;
    miscompares = 0;
    checks_done = 0;
    rst_n_in    = 1'b0;
    u_host.pulse_init();
    u_host.pulse_init();
    repeat (14) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    wait_ready();
    `CHK("page", `PAGE_RESET, page)
    `CHK("flags", 3'h0, {disp, stat, rmw})
    $display("reset test done");
    fill_test();
    for (int i = 0; i < 4; i++) begin
      rmw_test();
      soft_reset_test();
      ps_test(i[0]);
    end
    // Init pin edge in mid-run, with settings changed first
    u_host.wr_cmd({`CMD_START_PREFIX, 5'h1F});
    u_host.wr_cmd(`CMD_RMW_ENTER);
    u_host.pulse_init();
    wait_ready();
    `CHK("start", `START_RESET, start_line)
    `CHK("flags", 3'h0, {disp, stat, rmw})
    $display("init pin test done");
    finish_test();
  end
endmodule : lcd_rmw_reset_powersave_ctrl_tb_top
